// file: rtl/oslb_pkg.sv
// Package with register map, widths and timing for the one-second latch bank
package oslb_pkg;
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned TICK_PERIOD_MS = 1000;
  localparam int unsigned TICK_CYCLES = (CLK_HZ / 1000) * TICK_PERIOD_MS;
  localparam int unsigned TICK_W = 24;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned EBIT_W = 10;
  localparam int unsigned FAS_W = 8;
  localparam int unsigned BPV_W = 16;
  localparam int unsigned CRC_W = 10;
  localparam logic [4:0] OFS_EBIT_HI = 5'h10;
  localparam logic [4:0] OFS_EBIT_LO = 5'h11;
  localparam logic [4:0] OFS_FAS = 5'h12;
  localparam logic [4:0] OFS_BPV_HI = 5'h13;
  localparam logic [4:0] OFS_BPV_LO = 5'h14;
  localparam logic [4:0] OFS_CRC_HI = 5'h15;
  localparam logic [4:0] OFS_CRC_LO = 5'h16;
  localparam logic [7:0] RD_ZERO = 8'h00;
  localparam logic [1:0] RD_IDLE = 2'b01;
  localparam logic [1:0] RD_DONE = 2'b10;
endpackage

// file: rtl/oslb_counter.sv
// Saturating event counter with one-second capture into a holding register
`timescale 1ns/1ns
module oslb_counter #(
  parameter int unsigned W = 8
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic event_i,
  input wire logic tick_i,
  output logic [W-1:0] latched_o
);
  logic [W-1:0] run_q;
  logic [W-1:0] run_d;
  logic [W-1:0] lat_q;
  logic [W-1:0] lat_d;
  localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};
  localparam logic [W-1:0] MAX = {W{1'b1}};

  // Next running and latched values
  always_comb begin
    run_d = run_q;
    lat_d = lat_q;
    if (tick_i) begin
      lat_d = run_q;
      // restart after latch; event in tick cycle counted fresh
      run_d = event_i ? ONE : '0;
    end else if (event_i && run_q != MAX) begin
      run_d = run_q + ONE;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      run_q <= '0;
      lat_q <= '0;
    end else begin
      run_q <= run_d;
      lat_q <= lat_d;
    end
  end

  assign latched_o = lat_q;
endmodule // oslb_counter

// file: rtl/oslb_latch_bank.sv
// Top of the one-second error latch bank with its register read port
`timescale 1ns/1ns
module oslb_latch_bank
  import oslb_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic ebit_err_i,
  input wire logic fas_err_i,
  input wire logic bpv_err_i,
  input wire logic crc_err_i,
  input wire logic rd_en_i,
  input wire logic [ADDR_W-1:0] rd_addr_i,
  output logic [DATA_W-1:0] rd_data_o,
  output logic rd_valid_o,
  output logic tick_o
);
  typedef enum logic [1:0] {
    OSLB_IDLE = RD_IDLE,
    OSLB_DONE = RD_DONE
  } oslb_rd_t;

  logic [TICK_W-1:0] tcnt_q;
  logic [TICK_W-1:0] tcnt_d;
  logic tick_q;
  logic tick_d;
  logic [EBIT_W-1:0] ebit_lat;
  logic [FAS_W-1:0] fas_lat;
  logic [BPV_W-1:0] bpv_lat;
  logic [CRC_W-1:0] crc_lat;
  logic [DATA_W-1:0] data_q;
  logic [DATA_W-1:0] data_d;
  oslb_rd_t st_q;
  oslb_rd_t st_d;
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_LEN - 1);
  localparam logic [TICK_W-1:0] TICK_ONE = 24'h000001;

  // One-second divider; tick is a one-cycle enable
  always_comb begin
    tick_d = 1'b0;
    tcnt_d = tcnt_q + TICK_ONE;
    if (tcnt_q == TICK_LAST) begin
      tcnt_d = '0;
      tick_d = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tcnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tcnt_q <= tcnt_d;
      tick_q <= tick_d;
    end
  end

  // one shared tick for all bytes
  oslb_counter #(.W(EBIT_W)) u_ebit (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .event_i(ebit_err_i),
    .tick_i(tick_q),
    .latched_o(ebit_lat)
  );

  oslb_counter #(.W(FAS_W)) u_fas (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .event_i(fas_err_i),
    .tick_i(tick_q),
    .latched_o(fas_lat)
  );

  oslb_counter #(.W(BPV_W)) u_bpv (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .event_i(bpv_err_i),
    .tick_i(tick_q),
    .latched_o(bpv_lat)
  );

  oslb_counter #(.W(CRC_W)) u_crc (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .event_i(crc_err_i),
    .tick_i(tick_q),
    .latched_o(crc_lat)
  );

  // Read mux and answer state; data registered so outputs are flops
  always_comb begin
    data_d = data_q;
    st_d = OSLB_IDLE;
    if (rd_en_i) begin
      st_d = OSLB_DONE;
      unique case (rd_addr_i)
        OFS_EBIT_HI: data_d = {6'h00, ebit_lat[9:8]};
        OFS_EBIT_LO: data_d = ebit_lat[7:0];
        OFS_FAS: data_d = fas_lat;
        OFS_BPV_HI: data_d = bpv_lat[15:8];
        OFS_BPV_LO: data_d = bpv_lat[7:0];
        OFS_CRC_HI: data_d = {6'h00, crc_lat[9:8]};
        OFS_CRC_LO: data_d = crc_lat[7:0];
        default: data_d = RD_ZERO;
      endcase
    end
  end

  always_ff @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      data_q <= RD_ZERO;
      st_q <= OSLB_IDLE;
    end else begin
      data_q <= data_d;
      st_q <= st_d;
    end
  end

  assign rd_data_o = data_q;
  // One-hot done bit straight from the state flop
  assign rd_valid_o = st_q[1];
  assign tick_o = tick_q;
endmodule // oslb_latch_bank

// file: tb/oslb_chk.sv
// Checker on the latch bank read port and tick
`timescale 1ns/1ns
module oslb_chk #(parameter int unsigned TICK_LEN = 300) (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic rd_en_i,
  input wire logic [4:0] rd_addr_i,
  input wire logic [7:0] rd_data_o,
  input wire logic rd_valid_o,
  input wire logic tick_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Two reads of one offset; the latch moves on the edge that samples tick high
  sequence same_rd_s;
    (rd_en_i && !tick_o) ##1 (rd_en_i && $stable(rd_addr_i));
  endsequence
  rd_answer_a: assert property (rd_en_i |=> rd_valid_o) else $error("no answer");
  rd_quiet_a: assert property (!rd_en_i |=> !rd_valid_o && $stable(rd_data_o))
    else $error("idle change");
  ebit_pad_a: assert property (rd_en_i && rd_addr_i == 5'h10 |=> rd_data_o[7:2] == 6'h00)
    else $error("pad");
  crc_pad_a: assert property (rd_en_i && rd_addr_i == 5'h15 |=> rd_data_o[7:2] == 6'h00)
    else $error("pad");
  unused_ofs_a: assert property (rd_en_i && (rd_addr_i < 5'h10 || rd_addr_i > 5'h16)
    |=> rd_data_o == 8'h00) else $error("unused");
  tick_pulse_a: assert property (tick_o |=> !tick_o) else $error("tick width");
  tick_period_a: assert property ($rose(tick_o) |-> ##TICK_LEN tick_o) else $error("period");
  pair_same_a: assert property (same_rd_s |=> $stable(rd_data_o)) else $error("torn");
endmodule // oslb_chk
bind oslb_latch_bank oslb_chk #(.TICK_LEN(TICK_LEN)) u_chk (.mclk_i, .rst_n_i, .rd_en_i,
  .rd_addr_i, .rd_data_o, .rd_valid_o, .tick_o);

// file: tb/oslb_line_model.sv
// Received line model raising error events
`timescale 1ns/1ns
module oslb_line_model (
  input wire logic mclk_i,
  output logic [3:0] ev_o
);
  initial ev_o = 4'h0;
  // Each line held high for its count, one count per cycle
  task automatic send(input int e, f, b, c);
    for (int i = 0; i < 290; i++) begin
      ev_o = {i < e, i < f, i < b, i < c};
      @(negedge mclk_i);
    end
    ev_o = 4'h0;
  endtask
endmodule // oslb_line_model

// file: tb/testbench.sv
// Testbench for the one-second latch bank
`timescale 1ns/1ns
module testbench;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, rd_en_i = 1'b0, rd_valid_o, tick_o;
  logic [4:0] rd_addr_i = 5'h00;
  logic [7:0] rd_data_o;
  logic [3:0] ev;
  logic [7:0] exp_tbl [7] = '{8'h01, 8'h04, 8'hff, 8'h01, 8'h0e, 8'h01, 8'h03};
  int fail_count = 0, checked = 0;
  initial forever #50 mclk_i = ~mclk_i;
  oslb_line_model i_line (.mclk_i, .ev_o(ev));
  oslb_latch_bank #(.TICK_LEN(300)) i_dut (.mclk_i, .rst_n_i, .ebit_err_i(ev[3]),
    .fas_err_i(ev[2]), .bpv_err_i(ev[1]), .crc_err_i(ev[0]), .rd_en_i, .rd_addr_i,
    .rd_data_o, .rd_valid_o, .tick_o);
  // Single compare point; four-state so an unknown never passes
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] exp);
    rd_en_i = 1'b1;
    rd_addr_i = a;
    @(negedge mclk_i);
    check("rd_valid_o", {7'h00, rd_valid_o}, 8'h01);
    check("rd_data_o", rd_data_o, exp);
  endtask
  // Stops at the falling edge inside the tick cycle; a missing tick counts as a failure
  task automatic wait_tick();
    for (int i = 0; i < 400 && tick_o !== 1'b1; i++) @(negedge mclk_i);
    check("tick_o", {7'h00, tick_o}, 8'h01);
  endtask
  task automatic final_report();
    if (fail_count == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge mclk_i);
    rst_n_i = 1'b1;
    // Whole page reads zero before any capture
    for (int a = 0; a < 32; a++) rd(a[4:0], 8'h00);
    rd_en_i = 1'b0;
    wait_tick();
    // Bursts start in the tick cycle; alignment count saturates
    i_line.send(260, 290, 270, 259);
    wait_tick();
    @(negedge mclk_i);
    for (int a = 0; a < 7; a++) rd(5'h10 + a[4:0], exp_tbl[a]);
    rd_en_i = 1'b0;
    wait_tick();
    @(negedge mclk_i);
    // Quiet second: counts restarted at the last capture
    for (int a = 16; a < 23; a++) rd(a[4:0], 8'h00);
    rd_en_i = 1'b0;
    final_report();
  end
  initial begin
    #500000;
    fail_count++;
    final_report();
  end
endmodule // testbench
